// ---- rtl/dio_pkg.sv ----
/*
 dio_pkg: constants, field layouts and carriers for the digital i/o pin logic.
 assumes a 50 MHz system clock and a 32-bit apb register bus.
*/
package dio_pkg;

   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int NPIN = 3;
   localparam int PWM_W = 24;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] CFG_BASE = 8'h00;
   localparam logic [7:0] PER_BASE = 8'h10;
   localparam logic [7:0] DUTY_BASE = 8'h20;
   localparam logic [7:0] STAT_OFF = 8'h30;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int MIN_LOW_US = 30;
   localparam int MIN_LOW_CYC = MIN_LOW_US * CLK_MHZ;
   localparam int CW = $clog2(MIN_LOW_CYC + 1);

   // ----------------------------------------
   // modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      DIO_FUNC_DEF = 2'b00,
      DIO_FUNC_IN = 2'b01,
      DIO_FUNC_OUT = 2'b10
   } dio_func_e;

   typedef enum logic [1:0] {
      DIO_SEL_FALSE = 2'b00,
      DIO_SEL_TRUE = 2'b01,
      DIO_SEL_PWM = 2'b10
   } dio_sel_e;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   // cfg word: func [1:0], inv [2], spare [3], sel [5:4]
   typedef struct packed {
      dio_sel_e sel;
      logic spare;
      logic inv;
      dio_func_e func;
   } dio_cfg_s;

   localparam dio_cfg_s CFG_RST = '{sel: DIO_SEL_FALSE, spare: 1'b0, inv: 1'b0, func: DIO_FUNC_DEF};
   localparam logic [PWM_W-1:0] PER_RST = 24'h000000;
   localparam logic [PWM_W-1:0] DUTY_RST = 24'h000000;

   typedef struct packed {
      logic [NPIN-1:0] out;
      logic [NPIN-1:0] oe;
   } dio_pins_s;

endpackage : dio_pkg

// ---- rtl/dio_port.sv ----
/*
 dio_port: three-pin digital i/o port with apb registers, level and pwm outputs,
 protection-clear pulse exchange, protection status and output-state pins.
 assumes pins have an external pull-up; pin inputs pass a two-flop synchronizer to mclk.
*/
`timescale 1ns/10ps
module dio_port
   import dio_pkg::*;
#(
   parameter int PW = PWM_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instrument state
   input wire logic prot_active,
   input wire logic out_on,
   output logic prot_clear,
   // terminal pins
   input wire logic [NPIN-1:0] pin_in,
   output dio_pins_s pins
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      dio_cfg_s [NPIN-1:0] cfg;
      logic [NPIN-1:0][PW-1:0] per;
      logic [NPIN-1:0][PW-1:0] duty;
      logic [NPIN-1:0][PW-1:0] pcnt;
      logic [NPIN-1:0] s1;
      logic [NPIN-1:0] s2;
      logic [CW-1:0] rxc;
      logic [CW-1:0] txc;
      logic on_prev;
      logic clr;
      dio_pins_s pins;
      logic [31:0] rdata;
   } dio_st_s;

   localparam logic [CW-1:0] MIN_C = CW'(MIN_LOW_CYC);

   dio_st_s r;
   dio_st_s next_r;
   logic [NPIN-1:0] sensed;
   logic hit;
   logic [31:0] rd;

   function automatic logic [7:0] adr(input logic [7:0] b, input int i);
      adr = b + 8'(4 * i);
   endfunction : adr

   // ----------------------------------------
   // sensed values and read mux
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         sensed[i] = r.s2[i] ^ r.cfg[i].inv;
      end
   end

   always_comb begin
      hit = 1'b0;
      rd = 32'h00000000;
      if (paddr == STAT_OFF) begin
         hit = 1'b1;
         rd = {26'h0, r.txc != '0, out_on, prot_active, sensed};
      end
      for (int i = 0; i < NPIN; i++) begin
         if (paddr == adr(CFG_BASE, i)) begin
            hit = 1'b1;
            rd = 32'(r.cfg[i]);
         end
         if (paddr == adr(PER_BASE, i)) begin
            hit = 1'b1;
            rd = 32'(r.per[i]);
         end
         if (paddr == adr(DUTY_BASE, i)) begin
            hit = 1'b1;
            rd = 32'(r.duty[i]);
         end
      end
   end

   assign pready = psel & penable;
   assign pslverr = psel & penable & ~hit;
   assign prdata = r.rdata;
   assign prot_clear = r.clr;
   assign pins = r.pins;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic v;
      logic lvl;
      logic oe;
      logic act;
      v = 1'b0;
      lvl = 1'b1;
      oe = 1'b0;
      act = 1'b0;
      next_r = r;
      next_r.s1 = pin_in;
      next_r.s2 = r.s1;
      next_r.on_prev = out_on;
      next_r.clr = 1'b0;

      // apb: data captured in setup, writes at access
      if (psel && !penable) begin
         next_r.rdata = rd;
      end
      if (psel && penable && pwrite) begin
         for (int i = 0; i < NPIN; i++) begin
            if (paddr == adr(CFG_BASE, i)) begin
               next_r.cfg[i] = dio_cfg_s'(pwdata[5:0]);
               next_r.cfg[i].spare = 1'b0;
            end
            if (paddr == adr(PER_BASE, i)) begin
               next_r.per[i] = pwdata[PW-1:0];
            end
            if (paddr == adr(DUTY_BASE, i)) begin
               next_r.duty[i] = pwdata[PW-1:0];
            end
         end
      end

      // pin one pulse receiver
      act = ~sensed[0];
      if (r.cfg[0].func == DIO_FUNC_DEF && r.txc == '0 && act) begin
         if (r.rxc != MIN_C) begin
            next_r.rxc = r.rxc + 1'b1;
         end
         if (r.rxc == MIN_C - 1'b1 && prot_active) begin
            next_r.clr = 1'b1;
         end
      end else begin
         next_r.rxc = '0;
      end

      // pin one pulse sender
      if (r.txc != '0) begin
         next_r.txc = r.txc - 1'b1;
      end else if (r.cfg[0].func == DIO_FUNC_DEF && out_on && !r.on_prev && !prot_active) begin
         next_r.txc = MIN_C;
      end

      // pin drivers
      for (int i = 0; i < NPIN; i++) begin
         if (r.cfg[i].func == DIO_FUNC_OUT && r.cfg[i].sel == DIO_SEL_PWM && r.per[i] != '0) begin
            if (r.pcnt[i] >= r.per[i] - 1'b1) begin
               next_r.pcnt[i] = '0;
            end else begin
               next_r.pcnt[i] = r.pcnt[i] + 1'b1;
            end
         end else begin
            next_r.pcnt[i] = '0;
         end
         v = 1'b0;
         oe = 1'b0;
         case (r.cfg[i].func)
            DIO_FUNC_OUT: begin
               oe = 1'b1;
               case (r.cfg[i].sel)
                  DIO_SEL_TRUE: v = 1'b1;
                  DIO_SEL_PWM: v = r.per[i] != '0 && r.pcnt[i] < r.duty[i];
                  default: v = 1'b0;
               endcase
            end
            DIO_FUNC_DEF: begin
               if (i == 0) begin
                  oe = r.txc != '0;
                  v = oe;
               end else if (i == 1) begin
                  oe = 1'b1;
                  v = prot_active;
               end else begin
                  oe = 1'b1;
                  v = out_on;
               end
            end
            default: begin
               oe = 1'b0;
               v = 1'b0;
            end
         endcase
         lvl = ~v ^ r.cfg[i].inv;
         next_r.pins.oe[i] = oe;
         next_r.pins.out[i] = oe ? lvl : 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.cfg <= {NPIN{CFG_RST}};
         r.per <= {NPIN{PER_RST}};
         r.duty <= {NPIN{DUTY_RST}};
         r.s1 <= '1;
         r.s2 <= '1;
         r.on_prev <= 1'b0;
         r.pins.out <= '1;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [CW:0] txlen;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txlen <= '0;
      end else if (pins.oe[0] && r.cfg[0].func == DIO_FUNC_DEF) begin
         txlen <= txlen + 1'b1;
      end else begin
         txlen <= '0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_on_edge;
      $rose(out_on) && !prot_active && r.txc == '0 && r.cfg[0].func == DIO_FUNC_DEF;
   endsequence

   sequence s_pulse_low;
      pins.oe[0] && pins.out[0] == r.cfg[0].inv;
   endsequence

   chk_input_plain: assert property (
      r.cfg[0].func == DIO_FUNC_IN && !r.cfg[0].inv && $stable(r.cfg[0])
      |-> sensed[0] == $past(pin_in[0], 2))
      else $error("plain input sense wrong");

   chk_input_inv: assert property (
      r.cfg[0].inv && $stable(r.cfg[0]) |-> sensed[0] == !$past(pin_in[0], 2))
      else $error("inverted input sense wrong");

   chk_out_true: assert property (
      r.cfg[1].func == DIO_FUNC_OUT && r.cfg[1].sel == DIO_SEL_TRUE
      |=> pins.oe[1] && pins.out[1] == $past(r.cfg[1].inv))
      else $error("true output level wrong");

   chk_out_false: assert property (
      r.cfg[2].func == DIO_FUNC_OUT && r.cfg[2].sel == DIO_SEL_FALSE
      |=> pins.oe[2] && pins.out[2] == !$past(r.cfg[2].inv))
      else $error("false output level wrong");

   chk_pwm_wrap: assert property (
      r.cfg[2].func == DIO_FUNC_OUT && r.cfg[2].sel == DIO_SEL_PWM && r.per[2] != '0
      && r.pcnt[2] == r.per[2] - 1'b1 && $stable(r.per[2]) |=> r.pcnt[2] == '0)
      else $error("pwm period wrap wrong");

   chk_reset_default: assert property (
      !$past(resetn) |-> r.cfg[0].func == DIO_FUNC_DEF && r.cfg[1].func == DIO_FUNC_DEF
      && r.cfg[2].func == DIO_FUNC_DEF)
      else $error("reset function not default");

   chk_clear_cause: assert property (
      prot_clear |-> $past(prot_active) && $past(r.rxc) == MIN_C - 1'b1)
      else $error("clear without valid pulse");

   chk_pulse_width: assert property (
      $fell(pins.oe[0]) && $past(r.cfg[0].func) == DIO_FUNC_DEF && $past(r.cfg[0].func, 2) == DIO_FUNC_DEF
      |-> txlen == CW'(MIN_LOW_CYC))
      else $error("sent pulse width wrong");

   chk_pulse_start: assert property (
      s_on_edge |-> ##[1:2] s_pulse_low)
      else $error("no pulse after switch on");

   chk_pulse_low: assert property (
      pins.oe[0] && r.cfg[0].func == DIO_FUNC_DEF && $stable(r.cfg[0]) |-> s_pulse_low)
      else $error("pulse not active low");

   chk_status_pin: assert property (
      r.cfg[1].func == DIO_FUNC_DEF && $stable(r.cfg[1])
      |=> pins.out[1] == (!$past(prot_active) ^ $past(r.cfg[1].inv)))
      else $error("status pin level wrong");

   chk_state_pin: assert property (
      r.cfg[2].func == DIO_FUNC_DEF && $stable(r.cfg[2])
      |=> pins.out[2] == (!$past(out_on) ^ $past(r.cfg[2].inv)))
      else $error("state pin level wrong");

   chk_pwm_level: assert property (
      r.cfg[2].func == DIO_FUNC_OUT && r.cfg[2].sel == DIO_SEL_PWM && r.per[2] != '0
      |=> pins.out[2] == (($past(r.pcnt[2]) >= $past(r.duty[2])) ^ $past(r.cfg[2].inv)))
      else $error("pwm output level wrong");

   chk_input_release: assert property (
      r.cfg[0].func == DIO_FUNC_IN |=> !pins.oe[0] && pins.out[0])
      else $error("input pin still driven");

   chk_status_drive: assert property (
      r.cfg[1].func == DIO_FUNC_DEF |=> pins.oe[1])
      else $error("status pin not driven");

   chk_state_drive: assert property (
      r.cfg[2].func == DIO_FUNC_DEF |=> pins.oe[2])
      else $error("state pin not driven");

   chk_clear_single: assert property (
      prot_clear |=> !prot_clear)
      else $error("clear pulse too long");

   chk_send_no_clear: assert property (
      r.txc != '0 |=> !prot_clear)
      else $error("clear taken while sending");

endmodule : dio_port

// ---- bench/dio_partner.sv ----
/*
 dio_partner: external instrument on the three terminal pins.
 assumes a pull-up on every pin and that pulse requests come from the bench.
*/
`timescale 1ns/10ps
module dio_partner
   import dio_pkg::*;
(
   // clock
   input wire logic mclk,
   // device side
   input dio_pins_s pins,
   output logic [NPIN-1:0] pin_in,
   // bench side
   input wire logic [15:0] low_cyc,
   input wire logic go,
   output logic [15:0] seen_wid,
   output logic [7:0] seen_cnt
);
   logic drv_low = 1'b0;
   logic [15:0] left = 16'h0000;
   logic [15:0] run = 16'h0000;
   // ----------------------------------------
   // wire level: pull-up, low wins
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         pin_in[i] = pins.oe[i] ? pins.out[i] : 1'b1;
      end
      if (drv_low) begin
         pin_in[0] = 1'b0;
      end
   end
   // ----------------------------------------
   // send low pulses, measure device pulses on pin one
   // ----------------------------------------
   initial begin
      seen_wid = 16'h0000;
      seen_cnt = 8'h00;
   end
   always @(posedge mclk) begin
      if (go && left == 16'h0000) begin
         drv_low <= 1'b1;
         left <= low_cyc;
      end else if (left > 16'h0001) begin
         left <= left - 16'h0001;
      end else if (left == 16'h0001) begin
         drv_low <= 1'b0;
         left <= 16'h0000;
      end
      if (pins.oe[0] && !pins.out[0]) begin
         run <= run + 16'h0001;
      end else if (run != 16'h0000) begin
         seen_wid <= run;
         seen_cnt <= seen_cnt + 8'h01;
         run <= 16'h0000;
      end
   end
endmodule : dio_partner

// ---- bench/digital_io_pin_functions_bench.sv ----
/*
 digital_io_pin_functions_bench: self-checking bench for dio_port.
 assumes dio_partner as the external instrument and zero-wait apb.
*/
`timescale 1ns/10ps
module digital_io_pin_functions_bench
   import dio_pkg::*;
;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic prot_active, out_on, prot_clear, go;
   logic [7:0] paddr;
   logic [7:0] seen_cnt;
   logic [31:0] pwdata, prdata, seed, re, rm;
   logic [15:0] low_cyc, seen_wid;
   logic [NPIN-1:0] pin_in;
   dio_pins_s pins;
   logic [31:0] rq[$];
   logic [31:0] mq[$];
   int n_errors = 0, comparisons = 0, cyc = 0, n_clr = 0, p, k, c, lows, per, duty;
   dio_port dio_port_i (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prot_active(prot_active), .out_on(out_on), .prot_clear(prot_clear), .pin_in(pin_in), .pins(pins));
   dio_partner dio_partner_i (.mclk(mclk), .pins(pins), .pin_in(pin_in), .low_cyc(low_cyc), .go(go),
      .seen_wid(seen_wid), .seen_cnt(seen_cnt));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task cmp_rd(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value rd at %0t: got %h exp %h", $time, g, e);
      end
   endtask : cmp_rd
   task cmp_pin(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value pin at %0t: got %h exp %h", $time, g, e);
      end
   endtask : cmp_pin
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
            input logic [31:0] m);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) begin
         rq.push_back(e);
         mq.push_back(m);
      end
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task pulse(input logic [15:0] w);
      @(posedge mclk);
      low_cyc <= w;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
   endtask : pulse
   task end_sim;
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   // ----------------------------------------
   // clock, watchers
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (prot_clear === 1'b1) n_clr <= n_clr + 1;
      if (psel && penable && pready && !pwrite && rq.size() > 0) begin
         re = rq.pop_front();
         rm = mq.pop_front();
         cmp_rd(prdata & rm, re);
      end
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {resetn, psel, penable, pwrite, prot_active, out_on, go, err} = 8'h00;
      {paddr, pwdata, low_cyc} = '0;
      seed = 32'h09D1;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      cmp_pin(pins.oe, 3'b110);
      cmp_pin(pins.out, 3'b111);
      for (p = 0; p < 3; p++) apb(1'b0, CFG_BASE + 8'(4 * p), 0, 32'(CFG_RST), 32'hFFFFFFFF);
      apb(1'b0, 8'hFC, 0, 0, 32'hFFFFFFFF);
      cmp_pin(err, 1'b1);
      for (p = 0; p < 3; p++) for (k = 0; k < 4; k++) begin
         apb(1'b1, CFG_BASE + 8'(4 * p), {26'h0, 1'b0, k[1], 1'b0, k[0], 2'b10}, 0, 0);
         repeat (2) @(posedge mclk);
         cmp_pin({pins.oe[p], pins.out[p]}, {1'b1, ~k[1] ^ k[0]});
      end
      for (k = 0; k < 6; k++) begin
         apb(1'b1, CFG_BASE + 8'(4 * (k / 2)), {29'h0, k[0], 2'b01}, 0, 0);
         repeat (4) @(posedge mclk);
         apb(1'b0, STAT_OFF, 0, {31'h0, ~k[0]} << (k / 2), 32'h1 << (k / 2));
      end
      apb(1'b1, CFG_BASE, 32'h1, 0, 0);
      pulse(16'd200);
      repeat (6) @(posedge mclk);
      apb(1'b0, STAT_OFF, 0, 0, 32'h1);
      for (k = 0; k < 2; k++) begin
         seed = xs(seed);
         per = 2 + seed % 8;
         duty = (seed >> 8) % per;
         apb(1'b1, PER_BASE + 8'h08, 32'(per), 0, 0);
         apb(1'b1, DUTY_BASE + 8'h08, 32'(duty), 0, 0);
         apb(1'b1, CFG_BASE + 8'h08, 32'h22, 0, 0);
         repeat (2 * per) @(posedge mclk);
         lows = 0;
         for (c = 0; c < 4 * per; c++) begin
            @(posedge mclk);
            if (pins.out[2] === 1'b0) lows++;
         end
         cmp_pin(lows, 4 * duty);
      end
      for (k = 0; k < 8; k++) begin
         apb(1'b1, CFG_BASE + 8'h04, {29'h0, k[2], 2'b00}, 0, 0);
         apb(1'b1, CFG_BASE + 8'h08, {29'h0, k[2], 2'b00}, 0, 0);
         prot_active <= k[0];
         out_on <= k[1];
         repeat (4) @(posedge mclk);
         cmp_pin(pins.out[2:1], {~k[1] ^ k[2], ~k[0] ^ k[2]});
      end
      apb(1'b1, CFG_BASE, 0, 0, 0);
      prot_active <= 1'b1;
      out_on <= 1'b0;
      pulse(16'd1400);
      repeat (1600) @(posedge mclk);
      cmp_pin(n_clr, 0);
      pulse(16'd1600);
      repeat (1800) @(posedge mclk);
      cmp_pin(n_clr, 1);
      c = seen_cnt;
      out_on <= 1'b1;
      repeat (1600) @(posedge mclk);
      cmp_pin(seen_cnt, c);
      prot_active <= 1'b0;
      out_on <= 1'b0;
      repeat (4) @(posedge mclk);
      out_on <= 1'b1;
      repeat (1600) @(posedge mclk);
      cmp_pin(seen_cnt, 8'(c + 1));
      cmp_pin(seen_wid, MIN_LOW_CYC);
      end_sim();
   end
endmodule : digital_io_pin_functions_bench
